// [rtl/maint_pkg.sv]
// Constants for the DRAM maintenance sequencer: timing, widths, command codes.
// Assumes a 200 MHz core clock; the forward clock is a separate domain.
package maint_pkg;
    localparam int CLK_PERIOD_NS = 5;
    // Least powerdown entry and exit latencies, rounded up to whole cycles.
    localparam int SLEEP_ENTRY_NS = 100;
    localparam int ENTRY_CYC = (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEEP_EXIT_NS = 200;
    localparam int EXIT_CYC = (SLEEP_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Spacing of internal refreshes in powerdown, a longest time, rounded down.
    localparam int INT_REF_NS = 1950;
    localparam int INT_REF_CYC = INT_REF_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] ENTRY_LOAD = CNT_W'(ENTRY_CYC - 1);
    localparam logic [CNT_W-1:0] EXIT_LOAD = CNT_W'(EXIT_CYC - 1);
    localparam logic [CNT_W-1:0] INT_REF_LOAD = CNT_W'(INT_REF_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;

    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int ROW_W = 12;
    localparam logic [BANK_W-1:0] BANK_MAX = 3'h7;
    localparam logic [BANK_W-1:0] BANK_ONE = 3'h1;
    localparam logic [ROW_W-1:0] ROW_ONE = 12'h001;
    localparam logic [ROW_W-1:0] ROW_RESET = 12'h000;
    localparam logic [BANK_W-1:0] BANK_RESET = 3'h0;

    // Request command codes on the request bus.
    localparam int CMD_W = 3;
    localparam logic [CMD_W-1:0] NOP_CMD = 3'h0;
    localparam logic [CMD_W-1:0] REFRESH_ACTIVATE_CMD = 3'h1;
    localparam logic [CMD_W-1:0] REFRESH_ACTIVATE_INCREMENT_CMD = 3'h2;
    localparam logic [CMD_W-1:0] REFRESH_PRECHARGE_CMD = 3'h3;
    localparam logic [CMD_W-1:0] CURRENT_CAL_BEGIN_CMD = 3'h4;
    localparam logic [CMD_W-1:0] TERMINATION_CAL_BEGIN_CMD = 3'h5;
    localparam logic [CMD_W-1:0] CAL_END_CMD = 3'h6;
    localparam logic [CMD_W-1:0] POWERDOWN_ENTRY_CMD = 3'h7;

    // Serial register map, power state control only.
    localparam int SER_W = 8;
    localparam logic [SER_W-1:0] POWER_STATE_CONTROL_ADDR = 8'h03;
    localparam logic [SER_W-1:0] POWER_STATE_CONTROL_RESET = 8'h00;
    localparam logic [SER_W-1:0] WAKE_VALUE = 8'h01;
    localparam int POWERDOWN_EXIT_BIT = 0;
    localparam int SER_SYNC_W = 2 * SER_W + 2;
endpackage

// [rtl/maint_seq.sv]
// DRAM maintenance sequencer: refresh, calibration acceptance, power states.
// Assumes request fields are stable on the forward clock and serial pins are
// held by the controller for several core cycles per write strobe.
// Contract
// - Refresh activate opens bank at refresh row; increment variant then bumps row.
// - Termination calibration sequence is accepted but causes no action.
// - Two power states; powerdown keeps cells via internal refresh.
// - Powerdown is entered after the entry latency following the command.
// - Powerdown refresh steps bank counter; wrap increments refresh row.
// - Broadcast write of one to power state register sets exit bit, wakes device.
// - Active state is reached after exit latency from the waking write.
// - No internal refresh during exit except one falling due in the waking cycle; controller adds catch-up refreshes.
// - Refresh activate opens the bank like an activate, row from refresh row.
// - Refresh precharge closes the addressed bank like a precharge.
`timescale 1ns/1ps
`default_nettype none

module maint_seq (
    // Core clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Request side, forward clock domain
    input wire logic fwd_clk_in,
    input wire logic req_valid_in,
    input wire logic [maint_pkg::CMD_W-1:0] req_cmd_in,
    input wire logic [maint_pkg::BANK_W-1:0] req_bank_in,
    // Serial register write pins, asynchronous
    input wire logic ser_wr_in,
    input wire logic ser_bcast_in,
    input wire logic [maint_pkg::SER_W-1:0] ser_addr_in,
    input wire logic [maint_pkg::SER_W-1:0] ser_data_in,
    // Status
    output logic powerdown_out,
    output logic active_out,
    output logic [maint_pkg::SER_W-1:0] power_state_control_out,
    output logic [maint_pkg::NUM_BANKS-1:0] bank_open_out,
    output logic [maint_pkg::ROW_W-1:0] refresh_row_out,
    output logic [maint_pkg::BANK_W-1:0] refresh_bank_out,
    output logic [maint_pkg::ROW_W-1:0] act_row_out,
    output logic int_refresh_out,
    output logic [maint_pkg::BANK_W-1:0] int_refresh_bank_out,
    output logic cur_cal_busy_out
);

    typedef enum logic [1:0] {st_active, st_entry, st_powerdown, st_exit} pstate_t;

    function automatic logic [maint_pkg::NUM_BANKS-1:0] bank_sel(
        input logic [maint_pkg::BANK_W-1:0] b);
        bank_sel = '0;
        bank_sel[b] = 1'b1;
    endfunction

    // Forward clock domain: capture each valid non-NOP command and flag it with a toggle.
    logic [maint_pkg::CMD_W-1:0] lk_cmd_r;
    logic [maint_pkg::BANK_W-1:0] lk_bank_r;
    logic lk_tog_r;

    always_ff @(posedge fwd_clk_in or posedge rst_in) begin
        if (rst_in) begin
            lk_cmd_r <= maint_pkg::NOP_CMD;
            lk_bank_r <= maint_pkg::BANK_RESET;
            lk_tog_r <= 1'b0;
        end else if (req_valid_in && req_cmd_in != maint_pkg::NOP_CMD) begin
            lk_cmd_r <= req_cmd_in;
            lk_bank_r <= req_bank_in;
            lk_tog_r <= ~lk_tog_r;
        end
    end

    // The held command is read only after its toggle has crossed, and the next
    // forward edge is far later, so the fields are stable when sampled.
    logic tog_s1_r;
    logic tog_s2_r;
    logic tog_s3_r;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
        end else begin
            tog_s1_r <= lk_tog_r;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
        end
    end

    // Serial pins pass two flip-flops each.
    logic [maint_pkg::SER_SYNC_W-1:0] ser_raw;
    logic [maint_pkg::SER_SYNC_W-1:0] ser_s1_r;
    logic [maint_pkg::SER_SYNC_W-1:0] ser_s2_r;
    logic ser_wr_d_r;

    assign ser_raw = {ser_wr_in, ser_bcast_in, ser_addr_in, ser_data_in};

    genvar gi;
    generate
        for (gi = 0; gi < maint_pkg::SER_SYNC_W; gi++) begin : g_ser_sync
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    ser_s1_r[gi] <= 1'b0;
                    ser_s2_r[gi] <= 1'b0;
                end else begin
                    ser_s1_r[gi] <= ser_raw[gi];
                    ser_s2_r[gi] <= ser_s1_r[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ser_wr_d_r <= 1'b0;
        end else begin
            ser_wr_d_r <= ser_s2_r[maint_pkg::SER_SYNC_W-1];
        end
    end

    logic ser_wr_s;
    logic ser_bcast_s;
    logic [maint_pkg::SER_W-1:0] ser_addr_s;
    logic [maint_pkg::SER_W-1:0] ser_data_s;
    logic psc_write;
    logic wake;

    assign ser_wr_s = ser_s2_r[maint_pkg::SER_SYNC_W-1];
    assign ser_bcast_s = ser_s2_r[maint_pkg::SER_SYNC_W-2];
    assign ser_addr_s = ser_s2_r[2*maint_pkg::SER_W-1:maint_pkg::SER_W];
    assign ser_data_s = ser_s2_r[maint_pkg::SER_W-1:0];
    // A write completes on the falling edge of the write strobe.
    assign psc_write = ser_wr_d_r && !ser_wr_s && ser_bcast_s
        && ser_addr_s == maint_pkg::POWER_STATE_CONTROL_ADDR;
    assign wake = psc_write && ser_data_s == maint_pkg::WAKE_VALUE;

    // Power state machine.
    pstate_t state_r;
    logic [maint_pkg::CNT_W-1:0] lat_cnt_r;
    logic powerdown_r;
    logic active_r;

    logic ev;
    logic in_active;
    logic ev_ref_open;
    logic ev_ref_open_inc;
    logic ev_act;
    logic ev_ref_close;
    logic ev_sleep;
    logic ev_cal_begin;
    logic ev_cal_end;

    assign ev = tog_s2_r ^ tog_s3_r;
    assign in_active = state_r == st_active;
    // Requests are ignored outside the active state.
    assign ev_ref_open = ev && in_active && lk_cmd_r == maint_pkg::REFRESH_ACTIVATE_CMD;
    assign ev_ref_open_inc = ev && in_active
        && lk_cmd_r == maint_pkg::REFRESH_ACTIVATE_INCREMENT_CMD;
    assign ev_act = ev_ref_open || ev_ref_open_inc;
    assign ev_ref_close = ev && in_active && lk_cmd_r == maint_pkg::REFRESH_PRECHARGE_CMD;
    assign ev_sleep = ev && in_active && lk_cmd_r == maint_pkg::POWERDOWN_ENTRY_CMD;
    assign ev_cal_begin = ev && in_active && lk_cmd_r == maint_pkg::CURRENT_CAL_BEGIN_CMD;
    assign ev_cal_end = ev && in_active && lk_cmd_r == maint_pkg::CAL_END_CMD;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= st_active;
            lat_cnt_r <= maint_pkg::CNT_ZERO;
            powerdown_r <= 1'b0;
            active_r <= 1'b1;
        end else begin
            case (state_r)
                st_active: begin
                    if (ev_sleep) begin
                        state_r <= st_entry;
                        lat_cnt_r <= maint_pkg::ENTRY_LOAD;
                        active_r <= 1'b0;
                    end
                end
                st_entry: begin
                    if (wake) begin
                        state_r <= st_exit;
                        lat_cnt_r <= maint_pkg::EXIT_LOAD;
                    end else if (lat_cnt_r == maint_pkg::CNT_ZERO) begin
                        state_r <= st_powerdown;
                        powerdown_r <= 1'b1;
                    end else begin
                        lat_cnt_r <= lat_cnt_r - maint_pkg::CNT_ONE;
                    end
                end
                st_powerdown: begin
                    if (wake) begin
                        state_r <= st_exit;
                        lat_cnt_r <= maint_pkg::EXIT_LOAD;
                        powerdown_r <= 1'b0;
                    end
                end
                st_exit: begin
                    if (lat_cnt_r == maint_pkg::CNT_ZERO) begin
                        state_r <= st_active;
                        active_r <= 1'b1;
                    end else begin
                        lat_cnt_r <= lat_cnt_r - maint_pkg::CNT_ONE;
                    end
                end
                default: begin
                    state_r <= st_active;
                    active_r <= 1'b1;
                    powerdown_r <= 1'b0;
                end
            endcase
        end
    end

    // Power state control register. The exit bit is cleared when a powerdown
    // entry command is taken; a waking write in the same cycle wins.
    logic [maint_pkg::SER_W-1:0] psc_r;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            psc_r <= maint_pkg::POWER_STATE_CONTROL_RESET;
        end else if (psc_write) begin
            psc_r <= ser_data_s;
        end else if (ev_sleep) begin
            psc_r[maint_pkg::POWERDOWN_EXIT_BIT] <= 1'b0;
        end
    end

    // Internal refresh timer runs only in powerdown; a refresh falling due in the waking cycle still fires in the first exit cycle.
    logic [maint_pkg::CNT_W-1:0] ref_cnt_r;
    logic int_ref_r;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ref_cnt_r <= maint_pkg::INT_REF_LOAD;
            int_ref_r <= 1'b0;
        end else if (state_r != st_powerdown) begin
            ref_cnt_r <= maint_pkg::INT_REF_LOAD;
            int_ref_r <= 1'b0;
        end else if (ref_cnt_r == maint_pkg::CNT_ZERO) begin
            ref_cnt_r <= maint_pkg::INT_REF_LOAD;
            int_ref_r <= 1'b1;
        end else begin
            ref_cnt_r <= ref_cnt_r - maint_pkg::CNT_ONE;
            int_ref_r <= 1'b0;
        end
    end

    // Refresh row register and refresh bank counter.
    logic [maint_pkg::ROW_W-1:0] row_r;
    logic [maint_pkg::BANK_W-1:0] bank_cnt_r;
    logic [maint_pkg::ROW_W-1:0] act_row_r;
    logic [maint_pkg::BANK_W-1:0] int_bank_r;
    logic int_pulse_r;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            row_r <= maint_pkg::ROW_RESET;
            bank_cnt_r <= maint_pkg::BANK_RESET;
            act_row_r <= maint_pkg::ROW_RESET;
            int_bank_r <= maint_pkg::BANK_RESET;
            int_pulse_r <= 1'b0;
        end else begin
            int_pulse_r <= int_ref_r;
            if (int_ref_r) begin
                int_bank_r <= bank_cnt_r;
                bank_cnt_r <= bank_cnt_r + maint_pkg::BANK_ONE;
                if (bank_cnt_r == maint_pkg::BANK_MAX) begin
                    row_r <= row_r + maint_pkg::ROW_ONE;
                end
            end else if (ev_act) begin
                act_row_r <= row_r;
                if (ev_ref_open_inc) begin
                    row_r <= row_r + maint_pkg::ROW_ONE;
                end
            end
        end
    end

    // Bank open tracking and current calibration status. Termination
    // calibration begin is decoded as a no-op and leaves no trace.
    logic [maint_pkg::NUM_BANKS-1:0] bank_open_r;
    logic cal_busy_r;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bank_open_r <= '0;
        end else if (ev_act) begin
            bank_open_r <= bank_open_r | bank_sel(lk_bank_r);
        end else if (ev_ref_close) begin
            bank_open_r <= bank_open_r & ~bank_sel(lk_bank_r);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cal_busy_r <= 1'b0;
        end else if (ev_cal_begin) begin
            cal_busy_r <= 1'b1;
        end else if (ev_cal_end) begin
            cal_busy_r <= 1'b0;
        end
    end

    assign powerdown_out = powerdown_r;
    assign active_out = active_r;
    assign power_state_control_out = psc_r;
    assign bank_open_out = bank_open_r;
    assign refresh_row_out = row_r;
    assign refresh_bank_out = bank_cnt_r;
    assign act_row_out = act_row_r;
    assign int_refresh_out = int_pulse_r;
    assign int_refresh_bank_out = int_bank_r;
    assign cur_cal_busy_out = cal_busy_r;

    // Checks.
    localparam int ENTRY_A = maint_pkg::ENTRY_CYC + 1;
    localparam int EXIT_A = maint_pkg::EXIT_CYC + 1;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_sleep_cmd;
        ev_sleep;
    endsequence
    sequence s_wake_pd;
        wake && state_r == st_powerdown;
    endsequence

    entry_lat_a: assert property (s_sleep_cmd |-> ##ENTRY_A
        (powerdown_out || state_r == st_exit))
        else $error("powerdown not entered after entry latency");
    exit_lat_a: assert property (s_wake_pd |-> ##EXIT_A active_out)
        else $error("active state not reached after exit latency");
    wake_leave_a: assert property (s_wake_pd |=> !powerdown_out
        && state_r == st_exit)
        else $error("waking write did not leave powerdown");
    row_incr_a: assert property (ev_ref_open_inc |=> row_r == $past(row_r)
        + maint_pkg::ROW_ONE && act_row_r == $past(row_r))
        else $error("row not used then incremented");
    row_hold_a: assert property (ev_ref_open |=> row_r == $past(row_r))
        else $error("refresh activate changed the row");
    bank_open_a: assert property (ev_act |=> bank_open_out[$past(lk_bank_r)])
        else $error("activated bank not open");
    bank_close_a: assert property (ev_ref_close |=> !bank_open_out[$past(lk_bank_r)])
        else $error("precharged bank still open");
    int_ref_pd_a: assert property (int_ref_r |-> state_r == st_powerdown)
        else $error("internal refresh outside powerdown");
    wrap_row_a: assert property (int_ref_r && bank_cnt_r == maint_pkg::BANK_MAX
        |=> row_r == $past(row_r) + maint_pkg::ROW_ONE && bank_cnt_r == '0)
        else $error("bank counter wrap did not bump row");
    exit_no_ref_a: assert property (state_r == st_exit |-> ##1 !int_refresh_out)
        else $error("internal refresh during exit");

endmodule // maint_seq

`default_nettype wire

// [testbench/ctrl_model.sv]
// Memory controller model: issues request packets on the forward clock and
// serial register writes. Assumes the forward clock is made by the bench.
`timescale 1ns/1ps
`default_nettype none

module ctrl_model #(
    parameter int QUIET_FWD = 2
) (
    // Clocks
    input wire logic clk_in,
    input wire logic fwd_clk_in,
    // Request bus
    output logic req_valid_out,
    output logic [maint_pkg::CMD_W-1:0] req_cmd_out,
    output logic [maint_pkg::BANK_W-1:0] req_bank_out,
    // Serial write pins
    output logic ser_wr_out,
    output logic ser_bcast_out,
    output logic [maint_pkg::SER_W-1:0] ser_addr_out,
    output logic [maint_pkg::SER_W-1:0] ser_data_out
);
    logic [maint_pkg::NUM_BANKS-1:0] open_r;

    initial begin
        open_r = 8'h00;
        req_valid_out = 1'b0;
        req_cmd_out = 3'h0;
        req_bank_out = 3'h0;
        ser_wr_out = 1'b0;
        ser_bcast_out = 1'b0;
        ser_addr_out = 8'h00;
        ser_data_out = 8'h00;
    end

    // Idle request lines carry the inverse of the last value, never a stale copy.
    task automatic send(input logic [2:0] cmd, input logic [2:0] bank);
        @(negedge fwd_clk_in);
        req_valid_out = 1'b1;
        req_cmd_out = cmd;
        req_bank_out = bank;
        @(posedge fwd_clk_in);
        @(negedge fwd_clk_in);
        req_valid_out = 1'b0;
        req_cmd_out = ~cmd;
        req_bank_out = ~bank;
        if (cmd == maint_pkg::REFRESH_PRECHARGE_CMD) begin
            open_r[bank] = 1'b0;
        end else if (cmd == maint_pkg::REFRESH_ACTIVATE_CMD ||
                     cmd == maint_pkg::REFRESH_ACTIVATE_INCREMENT_CMD) begin
            open_r[bank] = 1'b1;
        end
    endtask

    task automatic quiet();
        repeat (QUIET_FWD) @(posedge fwd_clk_in);
    endtask

    task automatic burst_act(input logic inc_last);
        for (int b = 0; b < maint_pkg::NUM_BANKS; b++) begin
            if (!open_r[b]) begin
                send((b == 7 && inc_last) ? maint_pkg::REFRESH_ACTIVATE_INCREMENT_CMD :
                     maint_pkg::REFRESH_ACTIVATE_CMD, 3'(b));
            end
        end
    endtask

    task automatic burst_pre();
        for (int b = 0; b < maint_pkg::NUM_BANKS; b++) begin
            send(maint_pkg::REFRESH_PRECHARGE_CMD, 3'(b));
        end
    endtask

    task automatic cal(input logic [2:0] begin_cmd);
        quiet();
        send(begin_cmd, 3'h0);
        quiet();
        send(maint_pkg::CAL_END_CMD, 3'h0);
        quiet();
    endtask

    task automatic ser_write(input logic bcast, input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_in);
        ser_bcast_out = bcast;
        ser_addr_out = addr;
        ser_data_out = data;
        ser_wr_out = 1'b1;
        repeat (4) @(negedge clk_in);
        ser_wr_out = 1'b0;
        repeat (4) @(negedge clk_in);
        ser_bcast_out = ~bcast;
        ser_addr_out = ~addr;
        ser_data_out = ~data;
    endtask
endmodule // ctrl_model

`default_nettype wire

// [testbench/dram_maintenance_sequencing_test.sv]
// Testbench for the maintenance sequencer: refresh, calibration, power states.
// Assumes the controller model in ctrl_model.sv and the design package.
`timescale 1ns/1ps
`default_nettype none

module dram_maintenance_sequencing_test;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic fwd_clk_in = 1'b0;
    logic fwd_run = 1'b1;
    logic req_valid_in;
    logic [2:0] req_cmd_in;
    logic [2:0] req_bank_in;
    logic ser_wr_in;
    logic ser_bcast_in;
    logic [7:0] ser_addr_in;
    logic [7:0] ser_data_in;
    logic powerdown_out;
    logic active_out;
    logic [7:0] power_state_control_out;
    logic [7:0] bank_open_out;
    logic [11:0] refresh_row_out;
    logic [2:0] refresh_bank_out;
    logic [11:0] act_row_out;
    logic int_refresh_out;
    logic [2:0] int_refresh_bank_out;
    logic cur_cal_busy_out;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    // The catch-up count rests on timings this bench does not model; a plain default.
    localparam int CATCHUP_REFRESHES = 16;

    always #2.5 clk_in = ~clk_in;

    // The forward clock parks low while stopped, as in powerdown.
    initial begin
        #1.3;
        forever begin
            #62.5;
            fwd_clk_in = fwd_run ? ~fwd_clk_in : 1'b0;
        end
    end

    maint_seq maint_seq_inst (.clk_in(clk_in), .rst_in(rst_in), .fwd_clk_in(fwd_clk_in),
        .req_valid_in(req_valid_in), .req_cmd_in(req_cmd_in), .req_bank_in(req_bank_in),
        .ser_wr_in(ser_wr_in), .ser_bcast_in(ser_bcast_in), .ser_addr_in(ser_addr_in),
        .ser_data_in(ser_data_in), .powerdown_out(powerdown_out), .active_out(active_out),
        .power_state_control_out(power_state_control_out), .bank_open_out(bank_open_out),
        .refresh_row_out(refresh_row_out), .refresh_bank_out(refresh_bank_out),
        .act_row_out(act_row_out), .int_refresh_out(int_refresh_out),
        .int_refresh_bank_out(int_refresh_bank_out), .cur_cal_busy_out(cur_cal_busy_out));

    ctrl_model ctrl_model_inst (.clk_in(clk_in), .fwd_clk_in(fwd_clk_in),
        .req_valid_out(req_valid_in), .req_cmd_out(req_cmd_in), .req_bank_out(req_bank_in),
        .ser_wr_out(ser_wr_in), .ser_bcast_out(ser_bcast_in), .ser_addr_out(ser_addr_in),
        .ser_data_out(ser_data_in));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Sized from the whole run of request packets and eight internal refreshes, plus margin.
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic test_reset();
        check("rst_pd", powerdown_out, 32'h0);
        check("rst_active", active_out, 32'h1);
        check("rst_psc", power_state_control_out, 32'h00);
        check("rst_banks", bank_open_out, 32'h00);
        check("rst_row", refresh_row_out, 32'h000);
        check("rst_bank", refresh_bank_out, 32'h0);
        check("rst_busy", cur_cal_busy_out, 32'h0);
    endtask

    task automatic test_refresh_burst();
        ctrl_model_inst.send(maint_pkg::NOP_CMD, 3'h5);
        check("other_req", bank_open_out, 32'h00);
        ctrl_model_inst.burst_act(1'b1);
        check("burst_open", bank_open_out, 32'hff);
        check("burst_act_row", act_row_out, 32'h000);
        check("burst_row", refresh_row_out, 32'h001);
        check("burst_bank", refresh_bank_out, 32'h0);
        ctrl_model_inst.burst_pre();
        check("burst_closed", bank_open_out, 32'h00);
    endtask

    task automatic test_calibration();
        repeat (2) begin
            ctrl_model_inst.quiet();
            ctrl_model_inst.send(maint_pkg::CURRENT_CAL_BEGIN_CMD, 3'h0);
            check("cal_busy", cur_cal_busy_out, 32'h1);
            ctrl_model_inst.send(maint_pkg::CAL_END_CMD, 3'h0);
            check("cal_done", cur_cal_busy_out, 32'h0);
        end
        ctrl_model_inst.cal(maint_pkg::TERMINATION_CAL_BEGIN_CMD);
        check("term_busy", cur_cal_busy_out, 32'h0);
        check("term_row", refresh_row_out, 32'h001);
        check("term_open", bank_open_out, 32'h00);
    endtask

    task automatic test_powerdown_entry();
        int n;
        ctrl_model_inst.burst_act(1'b0);
        ctrl_model_inst.burst_pre();
        check("entry_row", refresh_row_out, 32'h001);
        check("entry_act_row", act_row_out, 32'h001);
        ctrl_model_inst.quiet();
        ctrl_model_inst.send(maint_pkg::POWERDOWN_ENTRY_CMD, 3'h0);
        check("entry_active", active_out, 32'h0);
        check("entry_early", powerdown_out, 32'h0);
        n = 0;
        while (powerdown_out !== 1'b1 && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        check("entry_lat", n >= maint_pkg::ENTRY_CYC - 12 && n <= maint_pkg::ENTRY_CYC - 4,
              32'h1);
        ctrl_model_inst.send(maint_pkg::CURRENT_CAL_BEGIN_CMD, 3'h0);
        check("pd_refused", cur_cal_busy_out, 32'h0);
        ctrl_model_inst.quiet();
        fwd_run = 1'b0;
        for (int i = 0; i < 8; i++) begin
            n = 0;
            while (int_refresh_out !== 1'b1 && n < maint_pkg::INT_REF_CYC + 10) begin
                @(negedge clk_in);
                n++;
            end
            check("int_bank", int_refresh_bank_out, i);
            check("int_next", refresh_bank_out, (i + 1) % maint_pkg::NUM_BANKS);
            check("int_spacing", n <= maint_pkg::INT_REF_CYC + 4, 32'h1);
            @(negedge clk_in);
        end
        check("int_row", refresh_row_out, 32'h002);
        check("int_pd", powerdown_out, 32'h1);
    endtask

    task automatic test_powerdown_exit();
        int n;
        int pulses;
        ctrl_model_inst.ser_write(1'b0, 8'h03, 8'h01);
        ctrl_model_inst.ser_write(1'b1, 8'h04, 8'h01);
        repeat (4) @(negedge clk_in);
        check("wr_refused_pd", powerdown_out, 32'h1);
        check("wr_refused_psc", power_state_control_out, 32'h00);
        fwd_run = 1'b1;
        repeat (30) @(negedge clk_in);
        ctrl_model_inst.ser_write(1'b1, maint_pkg::POWER_STATE_CONTROL_ADDR,
                                  maint_pkg::WAKE_VALUE);
        n = 0;
        pulses = 0;
        while (active_out !== 1'b1 && n < maint_pkg::EXIT_CYC + 10) begin
            @(negedge clk_in);
            n++;
            if (int_refresh_out === 1'b1) begin
                pulses++;
            end
        end
        check("exit_psc", power_state_control_out, 32'h01);
        check("exit_pd", powerdown_out, 32'h0);
        check("exit_lat", n >= maint_pkg::EXIT_CYC - 8 && n <= maint_pkg::EXIT_CYC + 6,
              32'h1);
        check("exit_no_ref", pulses, 32'h0);
        ctrl_model_inst.quiet();
        ctrl_model_inst.burst_act(1'b1);
        check("exit_open", bank_open_out, 32'hff);
        check("exit_act_row", act_row_out, 32'h002);
        check("exit_row", refresh_row_out, 32'h003);
        ctrl_model_inst.burst_pre();
        check("exit_closed", bank_open_out, 32'h00);
        repeat (CATCHUP_REFRESHES / maint_pkg::NUM_BANKS) begin
            ctrl_model_inst.burst_act(1'b1);
            ctrl_model_inst.burst_pre();
        end
        check("catchup_row", refresh_row_out,
              32'(3 + CATCHUP_REFRESHES / maint_pkg::NUM_BANKS));
    endtask

    // A waking write inside the entry latency turns the entry into an exit.
    task automatic test_entry_abort();
        int n;
        ctrl_model_inst.burst_act(1'b0);
        ctrl_model_inst.burst_pre();
        ctrl_model_inst.quiet();
        ctrl_model_inst.send(maint_pkg::POWERDOWN_ENTRY_CMD, 3'h0);
        check("abort_clear", power_state_control_out, 32'h00);
        ctrl_model_inst.ser_write(1'b1, maint_pkg::POWER_STATE_CONTROL_ADDR,
                                  maint_pkg::WAKE_VALUE);
        n = 0;
        while (active_out !== 1'b1 && n < maint_pkg::EXIT_CYC + 10) begin
            @(negedge clk_in);
            n++;
        end
        check("abort_pd", powerdown_out, 32'h0);
        check("abort_lat", n >= maint_pkg::EXIT_CYC - 8 && n <= maint_pkg::EXIT_CYC + 6,
              32'h1);
        check("abort_bank", refresh_bank_out, 32'h0);
        ctrl_model_inst.quiet();
        ctrl_model_inst.burst_act(1'b1);
        check("abort_row", refresh_row_out,
              32'(4 + CATCHUP_REFRESHES / maint_pkg::NUM_BANKS));
        ctrl_model_inst.burst_pre();
    endtask

    initial begin
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        test_reset();
        test_refresh_burst();
        test_calibration();
        test_powerdown_entry();
        test_powerdown_exit();
        test_entry_abort();
        tally_and_finish();
    end
endmodule // dram_maintenance_sequencing_test

`default_nettype wire
